// ==== common/safety_eval_pkg.sv ====
// Purpose: Constants, encodings and register map of the safety contact input evaluator.
// Assumes: 25 MHz reference clock; byte addresses on a plain register port.
// Notes:   All offsets, reset values and cycle counts live here.
package safety_eval_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_FREQ_HZ   = 25_000_000;
	localparam int TICK_TIME_MS  = 1;
	localparam int MS_CYCLES     = CLK_FREQ_HZ / 1000 * TICK_TIME_MS;
	localparam int MS_CNT_W      = 15;
	localparam logic [MS_CNT_W-1:0] MS_LAST = MS_CNT_W'(MS_CYCLES - 1);

	localparam logic [7:0] FILTER_MIN_MS = 8'h03;
	localparam logic [7:0] FILTER_MAX_MS = 8'hFA;
	localparam int         SIM_W         = 10;

	// Test pulse schedule, in ms slots of one period
	localparam int         SLOT_W     = 5;
	localparam logic [4:0] SLOT_CH1   = 5'h00;
	localparam logic [4:0] SLOT_CH2   = 5'h10;

	// ----------------------------------------------------------------
	// Encodings
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_GUARD_DUAL   = 2'b00,
		MODE_GUARD_SINGLE = 2'b01,
		MODE_LOCK_FBK     = 2'b10,
		MODE_ENABLE_KEY   = 2'b11
	} mode_e;

	typedef enum logic [1:0] {
		TYPE_SINGLE = 2'b00,
		TYPE_DOUBLE = 2'b01,
		TYPE_MIXED  = 2'b10,
		TYPE_SPARE  = 2'b11
	} in_type_e;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [3:0] CTRL_OFS   = 4'h0;
	localparam logic [3:0] FILTER_OFS = 4'h4;
	localparam logic [3:0] SIMUL_OFS  = 4'h8;
	localparam logic [3:0] STATUS_OFS = 4'hC;

	// Control fields
	localparam int CTRL_W          = 10;
	localparam int CTRL_MODE_LSB   = 0;
	localparam int CTRL_TYPE_LSB   = 2;
	localparam int CTRL_RST_EN     = 4;
	localparam int CTRL_RST_MON    = 5;
	localparam int CTRL_TEST_EN    = 6;
	localparam int CTRL_START_EN   = 7;
	localparam int CTRL_ERR_EN     = 8;
	localparam int CTRL_SIM_EN     = 9;

	localparam logic [CTRL_W-1:0] CTRL_RESET   = 10'h004;
	localparam logic [7:0]        FILTER_RESET = 8'h03;
	localparam logic [SIM_W-1:0]  SIMUL_RESET  = 10'h064;

	// Status fields
	localparam int ST_EVAL    = 0;
	localparam int ST_FAULT   = 1;
	localparam int ST_START   = 2;
	localparam int ST_ARMED   = 3;
	localparam int ST_CH1     = 4;
	localparam int ST_CH2     = 5;
	localparam int ST_CFG_OK  = 6;
	localparam int ST_DISC    = 7;

endpackage

// ==== design/contact_debounce.sv ====
// Purpose: Debounce one contact line against a millisecond tick.
// Assumes: Raw input synchronous to the clock; filter time already clamped.
// Notes:   Level after reset is low, the de-energised contact state.
module contact_debounce (
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	input  wire logic       tick_in,
	input  wire logic       raw_in,
	input  wire logic [7:0] filt_ms_in,
	output logic            level_out
);

	logic       cand_q;
	logic       level_q;
	logic [7:0] cnt_q;
	wire        moved   = raw_in != cand_q;
	wire        pending = cand_q != level_q;
	wire        done    = (cnt_q + 8'h01) >= filt_ms_in;

	// Any bounce restarts the full wait
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cand_q  <= 1'b0;
			level_q <= 1'b0;
			cnt_q   <= 8'h00;
		end else if (moved) begin
			cand_q <= raw_in;
			cnt_q  <= 8'h00;
		end else if (!pending) begin
			cnt_q <= 8'h00;
		end else if (tick_in) begin
			if (done) begin
				level_q <= cand_q;
				cnt_q   <= 8'h00;
			end else begin
				cnt_q <= cnt_q + 8'h01;
			end
		end
	end

	assign level_out = level_q;

	level_on_tick_a: assert property (@(posedge clk_in) disable iff (rst_in)
		(level_q != $past(level_q)) |-> ($past(tick_in) && $past(cnt_q) + 8'h01 >= $past(filt_ms_in)))
		else $error("Filter level changed before the filter time ran out");

endmodule

// ==== design/safety_contact_input_evaluator.sv ====
// Purpose: Safety contact evaluator for guard, lock feedback and enable key contacts.
// Assumes: Field inputs and reset button synchronous to REF_CLK_IN.
// Notes:   Output is low after any fault until inputs return to safe state.
module safety_contact_input_evaluator #(
	parameter logic [safety_eval_pkg::MS_CNT_W-1:0] TICK_LAST_P = safety_eval_pkg::MS_LAST
) (
	input  wire logic        REF_CLK_IN,
	input  wire logic        RST_IN,
	input  wire logic [3:0]  REG_ADDR_IN,
	input  wire logic [31:0] REG_WDATA_IN,
	input  wire logic        REG_WR_IN,
	input  wire logic        REG_RD_IN,
	output logic      [31:0] REG_RDATA_OUT,
	input  wire logic        FIRST_CHANNEL_INPUT_IN,
	input  wire logic        SECOND_CHANNEL_INPUT_IN,
	input  wire logic        RESET_BUTTON_IN,
	output logic      [1:0]  TEST_PULSE_OUT,
	output logic             EVAL_OUT,
	output logic             ERROR_OUT
);

	// ----------------------------------------------------------------
	// Register port
	// ----------------------------------------------------------------
	logic [safety_eval_pkg::CTRL_W-1:0] ctrl_q;
	logic [7:0]                         filter_q;
	logic [safety_eval_pkg::SIM_W-1:0]  simul_q;
	logic [31:0]                        rdata_q;
	logic [7:0]                         status;

	wire wr_ctrl   = REG_WR_IN && (REG_ADDR_IN == safety_eval_pkg::CTRL_OFS);
	wire wr_filter = REG_WR_IN && (REG_ADDR_IN == safety_eval_pkg::FILTER_OFS);
	wire wr_simul  = REG_WR_IN && (REG_ADDR_IN == safety_eval_pkg::SIMUL_OFS);

	always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			ctrl_q   <= safety_eval_pkg::CTRL_RESET;
			filter_q <= safety_eval_pkg::FILTER_RESET;
			simul_q  <= safety_eval_pkg::SIMUL_RESET;
		end else begin
			if (wr_ctrl)
				ctrl_q <= REG_WDATA_IN[safety_eval_pkg::CTRL_W-1:0];
			if (wr_filter)
				filter_q <= REG_WDATA_IN[7:0];
			if (wr_simul)
				simul_q <= REG_WDATA_IN[safety_eval_pkg::SIM_W-1:0];
		end
	end

	wire [31:0] rd_mux =
		(REG_ADDR_IN == safety_eval_pkg::CTRL_OFS)   ? {22'h0_0000, ctrl_q} :
		(REG_ADDR_IN == safety_eval_pkg::FILTER_OFS) ? {24'h00_0000, filter_q} :
		(REG_ADDR_IN == safety_eval_pkg::SIMUL_OFS)  ? {22'h0_0000, simul_q} :
		(REG_ADDR_IN == safety_eval_pkg::STATUS_OFS) ? {24'h00_0000, status} :
		32'h0000_0000;

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
		if (RST_IN)
			rdata_q <= 32'h0000_0000;
		else
			rdata_q <= REG_RD_IN ? rd_mux : 32'h0000_0000;
	end

	assign REG_RDATA_OUT = rdata_q;

	// ----------------------------------------------------------------
	// Configuration decode
	// ----------------------------------------------------------------
	safety_eval_pkg::mode_e    mode;
	safety_eval_pkg::in_type_e itype;

	assign mode  = safety_eval_pkg::mode_e'(ctrl_q[safety_eval_pkg::CTRL_MODE_LSB +: 2]);
	assign itype = safety_eval_pkg::in_type_e'(ctrl_q[safety_eval_pkg::CTRL_TYPE_LSB +: 2]);

	wire rst_en    = ctrl_q[safety_eval_pkg::CTRL_RST_EN];
	wire rst_mon   = ctrl_q[safety_eval_pkg::CTRL_RST_MON];
	wire test_en   = ctrl_q[safety_eval_pkg::CTRL_TEST_EN];
	wire start_en  = ctrl_q[safety_eval_pkg::CTRL_START_EN];
	wire err_en    = ctrl_q[safety_eval_pkg::CTRL_ERR_EN];
	wire two_ch    = (itype == safety_eval_pkg::TYPE_DOUBLE) || (itype == safety_eval_pkg::TYPE_MIXED);
	wire mixed     = itype == safety_eval_pkg::TYPE_MIXED;

	// Contact types each mode accepts; anything else is a fault
	wire cfg_valid =
		(mode == safety_eval_pkg::MODE_GUARD_DUAL)   ? two_ch :
		(mode == safety_eval_pkg::MODE_GUARD_SINGLE) ? (itype == safety_eval_pkg::TYPE_SINGLE) :
		(mode == safety_eval_pkg::MODE_LOCK_FBK)     ? (itype != safety_eval_pkg::TYPE_SPARE) :
		(itype == safety_eval_pkg::TYPE_SINGLE) || (itype == safety_eval_pkg::TYPE_DOUBLE);

	// Simultaneity only for two-contact types; key mode never mixed
	wire sim_on = ctrl_q[safety_eval_pkg::CTRL_SIM_EN] && two_ch && cfg_valid;

	// Out-of-range filter values are clamped to the legal span
	wire [7:0] filt_ms =
		(filter_q < safety_eval_pkg::FILTER_MIN_MS) ? safety_eval_pkg::FILTER_MIN_MS :
		(filter_q > safety_eval_pkg::FILTER_MAX_MS) ? safety_eval_pkg::FILTER_MAX_MS : filter_q;

	// ----------------------------------------------------------------
	// Millisecond time base
	// ----------------------------------------------------------------
	logic [safety_eval_pkg::MS_CNT_W-1:0] ms_cnt_q;
	wire ms_tick = ms_cnt_q == TICK_LAST_P;

	always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
		if (RST_IN)
			ms_cnt_q <= '0;
		else
			ms_cnt_q <= ms_tick ? '0 : ms_cnt_q + 1'b1;
	end

	// ----------------------------------------------------------------
	// Test pulses and readback
	// ----------------------------------------------------------------
	logic [safety_eval_pkg::SLOT_W-1:0] slot_q;
	logic [1:0]                         tp_q;
	logic [1:0]                         hold_q;

	wire p1_low = test_en && (slot_q == safety_eval_pkg::SLOT_CH1);
	wire p2_low = test_en && two_ch && (slot_q == safety_eval_pkg::SLOT_CH2);

	always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			slot_q <= '0;
			tp_q   <= 2'b11;
			hold_q <= 2'b00;
		end else begin
			slot_q <= !test_en ? '0 : (ms_tick ? slot_q + 1'b1 : slot_q);
			tp_q   <= {~p2_low, ~p1_low};
			if (tp_q[0])
				hold_q[0] <= FIRST_CHANNEL_INPUT_IN;
			if (tp_q[1])
				hold_q[1] <= SECOND_CHANNEL_INPUT_IN;
		end
	end

	assign TEST_PULSE_OUT = tp_q;

	// A line still high while its feed is low is shorted to another live line
	wire tp_fail = ms_tick && ((!tp_q[0] && FIRST_CHANNEL_INPUT_IN) || (!tp_q[1] && SECOND_CHANNEL_INPUT_IN));

	// Pulse windows are masked from the filter so they do not read as openings
	wire raw1 = tp_q[0] ? FIRST_CHANNEL_INPUT_IN : hold_q[0];
	wire raw2 = tp_q[1] ? SECOND_CHANNEL_INPUT_IN : hold_q[1];

	// ----------------------------------------------------------------
	// Debounce; filter delay adds directly to response time
	// ----------------------------------------------------------------
	logic f1;
	logic f2;

	contact_debounce u_filt1 (
		.clk_in     (REF_CLK_IN),
		.rst_in     (RST_IN),
		.tick_in    (ms_tick),
		.raw_in     (raw1),
		.filt_ms_in (filt_ms),
		.level_out  (f1)
	);

	contact_debounce u_filt2 (
		.clk_in     (REF_CLK_IN),
		.rst_in     (RST_IN),
		.tick_in    (ms_tick),
		.raw_in     (raw2),
		.filt_ms_in (filt_ms),
		.level_out  (f2)
	);

	// ----------------------------------------------------------------
	// Contact interpretation
	// ----------------------------------------------------------------
	// Mixed pair: first channel is the NO contact, second the NC one
	wire a1      = f1;
	wire a2      = f2 ^ mixed;
	// Closed guard, locked guard or turned key all read as active
	wire active  = two_ch ? (a1 && a2) : a1;
	wire safe    = two_ch ? (!a1 && !a2) : !a1;
	wire discord = two_ch && (a1 ^ a2);

	// ----------------------------------------------------------------
	// Simultaneity and fault latch
	// ----------------------------------------------------------------
	logic [safety_eval_pkg::SIM_W-1:0] sim_cnt_q;
	logic                              fault_q;

	always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
		if (RST_IN)
			sim_cnt_q <= '0;
		else if (!(sim_on && discord))
			sim_cnt_q <= '0;
		else if (ms_tick && (sim_cnt_q != '1))
			sim_cnt_q <= sim_cnt_q + 1'b1;
	end

	wire sim_timeout = sim_on && discord && (sim_cnt_q >= simul_q);
	wire fault_cause = sim_timeout || tp_fail || !cfg_valid;

	// A new cause wins over the safe-state clear
	always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
		if (RST_IN)
			fault_q <= 1'b0;
		else if (fault_cause)
			fault_q <= 1'b1;
		else if (safe)
			fault_q <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Start-up test: one safe-then-active cycle after power-on only
	// ----------------------------------------------------------------
	logic saw_safe_q;
	logic start_done_q;

	// Filters wake up reading open; a closed guard at power-on must not count as opened
	wire settled = (raw1 == f1) && (!two_ch || (raw2 == f2));

	always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			saw_safe_q   <= 1'b0;
			start_done_q <= 1'b0;
		end else begin
			if (safe && settled)
				saw_safe_q <= 1'b1;
			if (saw_safe_q && active && !fault_q)
				start_done_q <= 1'b1;
		end
	end

	wire start_ok = !start_en || start_done_q;
	wire ready    = active && !fault_q && start_ok && cfg_valid;

	// ----------------------------------------------------------------
	// Reset handling
	// ----------------------------------------------------------------
	logic btn_prev_q;
	logic pend_q;
	logic armed_q;

	wire btn_rise = RESET_BUTTON_IN && !btn_prev_q;
	wire btn_fall = !RESET_BUTTON_IN && btn_prev_q;
	wire accept   = rst_mon ? (btn_fall && pend_q) : btn_rise;

	always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			btn_prev_q <= 1'b0;
			pend_q     <= 1'b0;
			armed_q    <= 1'b0;
		end else begin
			btn_prev_q <= RESET_BUTTON_IN;
			pend_q     <= ready && !accept && (btn_rise || pend_q);
			// Any loss of ready or control register write asks for a fresh reset
			armed_q    <= ready && !wr_ctrl && (accept || armed_q);
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	logic eval_q;
	logic error_q;

	always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			eval_q  <= 1'b0;
			error_q <= 1'b0;
		end else begin
			eval_q  <= ready && (!rst_en || armed_q);
			error_q <= err_en && fault_q;
		end
	end

	assign EVAL_OUT  = eval_q;
	assign ERROR_OUT = error_q;

	assign status = {discord, cfg_valid, f2, f1, armed_q, start_done_q, fault_q, eval_q};

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge REF_CLK_IN);
	endclocking
	default disable iff (RST_IN);

	sequence manual_press_s;
		!RESET_BUTTON_IN ##1 RESET_BUTTON_IN;
	endsequence

	// Rise of the pulse is held in pend_q, so only the fall is matched
	sequence monitored_pulse_s;
		RESET_BUTTON_IN ##1 !RESET_BUTTON_IN;
	endsequence

	property rearm_after_p(s, sel);
		(s ##0 (sel && ready && !wr_ctrl)) |=> armed_q;
	endproperty

	open_drops_out_a: assert property (!active |=> !EVAL_OUT)
		else $error("Output high while contacts not active");

	manual_edge_a: assert property ((!rst_mon && $rose(armed_q)) |->
		$past(RESET_BUTTON_IN, 1) && !$past(RESET_BUTTON_IN, 2))
		else $error("Manual reset accepted without a rising edge");

	monitored_fall_a: assert property ((rst_mon && $rose(armed_q)) |->
		!$past(RESET_BUTTON_IN, 1) && $past(RESET_BUTTON_IN, 2))
		else $error("Monitored reset accepted without a full pulse");

	manual_arms_a: assert property (rearm_after_p(manual_press_s, !rst_mon))
		else $error("Manual reset edge did not arm the output");

	monitored_arms_a: assert property (rearm_after_p(monitored_pulse_s, rst_mon && pend_q))
		else $error("Completed reset pulse did not arm the output");

	reset_required_a: assert property ((rst_en && !armed_q && !accept) |=> !EVAL_OUT)
		else $error("Output set without an accepted reset");

	no_reset_follow_a: assert property ((!rst_en && ready) |=> EVAL_OUT)
		else $error("Output did not follow inputs with reset disabled");

	startup_hold_a: assert property ((start_en && !start_done_q) |=> !EVAL_OUT)
		else $error("Output high before start-up test completed");

	fault_forces_low_a: assert property (fault_q |=> !EVAL_OUT ##1 (!EVAL_OUT || !fault_q))
		else $error("Output high while a fault is latched");

	sim_timeout_a: assert property ((sim_on && discord && ms_tick && sim_cnt_q >= simul_q) |=> fault_q ##1 !EVAL_OUT)
		else $error("Simultaneity timeout did not latch a fault");

	short_detect_a: assert property ((ms_tick && !tp_q[0] && FIRST_CHANNEL_INPUT_IN) |=> fault_q)
		else $error("Test pulse readback failure not detected");

	error_out_a: assert property ((err_en && fault_q) |=> ERROR_OUT)
		else $error("Error output not raised for a latched fault");

	key_no_sim_a: assert property ((mode == safety_eval_pkg::MODE_ENABLE_KEY && !two_ch) |-> sim_cnt_q == '0)
		else $error("Simultaneity timer ran for a single-contact key");

endmodule

// ==== verif/contact_switch_model.sv ====
// Purpose: Field contacts of a guard, lock or key switch as seen at the evaluator inputs.
// Assumes: A closed contact carries the feed it is wired to; an open line reads low.
// Notes:   Stuck channel and short to supply happen only when the bench asks.
module contact_switch_model (
	input  wire logic       act_in,
	input  wire logic       mixed_in,
	input  wire logic       single_in,
	input  wire logic       stuck2_in,
	input  wire logic       short_in,
	input  wire logic [1:0] feed_in,
	output logic            ch1_out,
	output logic            ch2_out
);
	timeunit 1ns;
	timeprecision 1ns;

	logic closed1;
	logic closed2;

	// NO contact on first channel, NC on second in a mixed pair
	assign closed1 = act_in;
	assign closed2 = single_in ? 1'b0 : (mixed_in ? !act_in : act_in & !stuck2_in);
	// A short to supply bypasses the test feed, so readback must catch it
	assign ch1_out = closed1 & (feed_in[0] | short_in);
	assign ch2_out = closed2 & feed_in[1];
endmodule

// ==== verif/safety_contact_input_evaluator_tb.sv ====
// Purpose: Self-checking bench for the safety contact input evaluator.
// Assumes: Millisecond tick shortened to MS cycles to keep the run small.
// Notes:   Filter stays at 3 ms; each contact change gets at least 5 ms to settle.
module safety_contact_input_evaluator_tb;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int MS = 100;

	logic        clk     = 1'b0;
	logic        rst     = 1'b1;
	logic [3:0]  addr    = 4'h0;
	logic [31:0] wdata   = 32'h0000_0000;
	logic        wr      = 1'b0;
	logic        rd      = 1'b0;
	logic        btn     = 1'b0;
	logic        act     = 1'b0;
	logic        mixed   = 1'b0;
	logic        single  = 1'b0;
	logic        stuck2  = 1'b0;
	logic        shorted = 1'b0;
	logic [31:0] rdata;
	logic        ch1;
	logic        ch2;
	logic [1:0]  pulse;
	logic        eval;
	logic        err;
	int          bad_count;
	int          samples_checked;

	safety_contact_input_evaluator #(
		.TICK_LAST_P (15'(MS - 1))
	) dut (
		.REF_CLK_IN              (clk),
		.RST_IN                  (rst),
		.REG_ADDR_IN             (addr),
		.REG_WDATA_IN            (wdata),
		.REG_WR_IN               (wr),
		.REG_RD_IN               (rd),
		.REG_RDATA_OUT           (rdata),
		.FIRST_CHANNEL_INPUT_IN  (ch1),
		.SECOND_CHANNEL_INPUT_IN (ch2),
		.RESET_BUTTON_IN         (btn),
		.TEST_PULSE_OUT          (pulse),
		.EVAL_OUT                (eval),
		.ERROR_OUT               (err)
	);

	contact_switch_model contacts (
		.act_in    (act),
		.mixed_in  (mixed),
		.single_in (single),
		.stuck2_in (stuck2),
		.short_in  (shorted),
		.feed_in   (pulse),
		.ch1_out   (ch1),
		.ch2_out   (ch2)
	);

	always #20 clk = ~clk;

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t ns: saw %h, wanted %h", $time, got, exp);
		end
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wait_ms(input int n);
		wait_cyc(n * MS);
	endtask

	task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		wr    <= 1'b1;
		addr  <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		rd   <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask

	task automatic ctrl(input logic [31:0] v);
		reg_wr(safety_eval_pkg::CTRL_OFS, v);
	endtask

	task automatic set_act(input logic v, input int ms);
		@(posedge clk);
		act <= v;
		wait_ms(ms);
	endtask

	// Button sits on the input right after the two contact channels
	task automatic press(input logic v);
		@(posedge clk);
		btn <= v;
		wait_cyc(5);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic test_regs;
		logic [31:0] d;
		reg_rd(safety_eval_pkg::CTRL_OFS, d);
		check(d, 32'h0000_0004);
		reg_rd(safety_eval_pkg::FILTER_OFS, d);
		check(d, 32'h0000_0003);
		reg_rd(safety_eval_pkg::SIMUL_OFS, d);
		check(d, 32'h0000_0064);
		reg_rd(4'h2, d);
		check(d, 32'h0000_0000);
		$display("register test done");
	endtask

	task automatic test_guard;
		logic [31:0] d;
		set_act(1'b1, 1);
		check(eval, 1'b0);
		wait_ms(4);
		check(eval, 1'b1);
		reg_rd(safety_eval_pkg::STATUS_OFS, d);
		check(d[5:4], 2'b11);
		set_act(1'b0, 5);
		check(eval, 1'b0);
		$display("guard follow test done");
	endtask

	task automatic test_resets;
		ctrl(32'h0000_0014);
		set_act(1'b1, 5);
		check(eval, 1'b0);
		press(1'b1);
		check(eval, 1'b1);
		press(1'b0);
		set_act(1'b0, 5);
		set_act(1'b1, 5);
		check(eval, 1'b0);
		ctrl(32'h0000_0034);
		press(1'b1);
		check(eval, 1'b0);
		press(1'b0);
		check(eval, 1'b1);
		set_act(1'b0, 5);
		$display("reset test done");
	endtask

	task automatic test_mixed;
		ctrl(32'h0000_0008);
		@(posedge clk);
		mixed <= 1'b1;
		wait_ms(5);
		check(eval, 1'b0);
		set_act(1'b1, 5);
		check(eval, 1'b1);
		set_act(1'b0, 5);
		check(eval, 1'b0);
		mixed <= 1'b0;
		$display("mixed contact test done");
	endtask

	task automatic test_single_modes;
		single <= 1'b1;
		for (int m = 1; m < 4; m++) begin
			ctrl(32'(m));
			set_act(1'b1, 5);
			check(eval, 1'b1);
			set_act(1'b0, 5);
			check(eval, 1'b0);
		end
		single <= 1'b0;
		$display("single contact modes test done");
	endtask

	task automatic test_simultaneity;
		reg_wr(safety_eval_pkg::SIMUL_OFS, 32'h0000_0002);
		ctrl(32'h0000_0104);
		stuck2 <= 1'b1;
		set_act(1'b1, 8);
		check({eval, err}, 2'b00);
		set_act(1'b0, 5);
		ctrl(32'h0000_0304);
		set_act(1'b1, 8);
		check({eval, err}, 2'b01);
		stuck2 <= 1'b0;
		set_act(1'b0, 5);
		check(err, 1'b0);
		set_act(1'b1, 5);
		check({eval, err}, 2'b10);
		set_act(1'b0, 5);
		$display("simultaneity test done");
	endtask

	task automatic test_pulses;
		int lo0;
		int lo1;
		lo0 = 0;
		lo1 = 0;
		ctrl(32'h0000_0144);
		set_act(1'b1, 5);
		// Exactly one 32 ms period, so each feed shows one full low slot
		for (int i = 0; i < 32 * MS; i++) begin
			wait_cyc(1);
			if (pulse[0] === 1'b0) lo0++;
			if (pulse[1] === 1'b0) lo1++;
		end
		check(32'(lo0), 32'(MS));
		check(32'(lo1), 32'(MS));
		check({eval, err}, 2'b10);
		shorted <= 1'b1;
		wait_ms(34);
		check({eval, err}, 2'b01);
		shorted <= 1'b0;
		set_act(1'b0, 5);
		check(err, 1'b0);
		$display("test pulse test done");
	endtask

	task automatic test_bad_config;
		logic [31:0] d;
		ctrl(32'h0000_010C);
		wait_cyc(4);
		check(err, 1'b1);
		reg_rd(safety_eval_pkg::STATUS_OFS, d);
		check(d[6], 1'b0);
		check(eval, 1'b0);
		$display("invalid config test done");
	endtask

	// Start-up test needs a fresh power-on with the guard already closed
	task automatic test_startup;
		logic [31:0] d;
		@(posedge clk);
		rst <= 1'b1;
		act <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		ctrl(32'h0000_0084);
		wait_ms(5);
		check(eval, 1'b0);
		reg_rd(safety_eval_pkg::STATUS_OFS, d);
		check(d[2], 1'b0);
		set_act(1'b0, 5);
		set_act(1'b1, 5);
		check(eval, 1'b1);
		reg_rd(safety_eval_pkg::STATUS_OFS, d);
		check(d[2], 1'b1);
		$display("start-up test done");
	endtask

	// ----------------------------------------------------------------
	// Run control
	// ----------------------------------------------------------------
	task automatic final_report;
		$display("comparisons %0d, mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		test_regs();
		test_guard();
		test_resets();
		test_mixed();
		test_single_modes();
		test_simultaneity();
		test_pulses();
		test_bad_config();
		test_startup();
		final_report();
	end

	// About 200 ms of contact time at MS cycles per ms; twice that is the limit
	initial begin
		#1_600_000;
		bad_count++;
		final_report();
	end
endmodule
